// *** aicsr_consts.svh ***
/*
  Constants of the analog input configuration and status register bank:
  word addresses, status and configuration bit positions, reset values,
  quality thresholds and timing counts.
  Assumes it is included by its bare name into the design modules.
*/
`ifndef AICSR_CONSTS_SVH
`define AICSR_CONSTS_SVH

// word addresses on the register port
`define AICSR_ADDR_LAST_DATA 4'hB
`define AICSR_ADDR_QUALITY 4'hC
`define AICSR_ADDR_CFG_STAT 4'hD
`define AICSR_ADDR_SECONDARY 4'hE

// configuration (write) bit positions
`define AICSR_CFG_CONFIGURE 0
`define AICSR_CFG_FORCE_ERR 1
`define AICSR_CFG_RATE_50HZ 8
`define AICSR_CFG_SELF_CAL 11

// status (read) bit positions
`define AICSR_ST_CONFIGURED 0
`define AICSR_ST_ERROR 1
`define AICSR_ST_WARMING 4
`define AICSR_ST_CAL_BAD 7
`define AICSR_ST_RATE_50HZ 8
`define AICSR_ST_SYSTEM_CALIBRATION_TRIGGER_FAIL 12
`define AICSR_ST_MEM_ERR 13
`define AICSR_ST_POINT_FAULT 15

// reset values of the configuration fields
`define AICSR_CFG_RESET 1'b0
`define AICSR_WORD_ZERO 16'h0000

// quality thresholds: current in microamps, voltage in 0.01 % of full scale
`define AICSR_CUR_LOW_UA 16'h09C4
`define AICSR_CUR_HIGH_UA 16'h6018
`define AICSR_VOLT_LIMIT 16'h2F44

// timing: clock rate, warm-up time and conversion rates
`define AICSR_CLK_MHZ 100
`define AICSR_WARM_MS 8160
`define AICSR_WARM_CYCLES (`AICSR_WARM_MS * 1000 * `AICSR_CLK_MHZ)
`define AICSR_RATE_60HZ 20
`define AICSR_RATE_50HZ 25
`define AICSR_RATE_CAL 2
`define AICSR_SAMPLE_60_CYCLES ((`AICSR_CLK_MHZ * 1000000) / `AICSR_RATE_60HZ)
`define AICSR_SAMPLE_50_CYCLES ((`AICSR_CLK_MHZ * 1000000) / `AICSR_RATE_50HZ)
`define AICSR_SAMPLE_CAL_CYCLES ((`AICSR_CLK_MHZ * 1000000) / `AICSR_RATE_CAL)
`define AICSR_CAL_SAMPLES 3'h4

`endif

// *** aicsr_ctrl_model.sv ***
/*
  Register master model standing in for the system controller.
  Assumes aicsr_pkg is compiled first and the slave never stalls.
*/
`timescale 1ns/1ps

module aicsr_ctrl_model (
  input wire logic mclk,
  output aicsr_pkg::aicsr_addr_t addr,
  output aicsr_pkg::aicsr_word_t wdata,
  output logic wr_stb,
  output logic rd_stb,
  input wire aicsr_pkg::aicsr_word_t rdata,
  input wire logic attention
);
  import aicsr_pkg::*;
  // config bits a controller uses outside factory diagnostics
  localparam aicsr_word_t USER_MASK = 16'h0B03;

  // idle bus from time zero
  initial begin
    addr = 4'h0;
    wdata = 16'h0000;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
  end

  // one-cycle write; raw lets a test send diagnostic bits on purpose
  task automatic write_word(input aicsr_addr_t a, input aicsr_word_t d, input logic raw);
    @(posedge mclk);
    addr <= a;
    wdata <= raw ? d : (d & USER_MASK);
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
    // stale qualifiers are inverted so nothing leans on old values
    addr <= ~a;
    wdata <= ~d;
  endtask

  // one-cycle read; the answer stands only in the following cycle
  task automatic read_word(input aicsr_addr_t a, output aicsr_word_t d, output logic att);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    addr <= ~a;
    #1;
    d = rdata;
    att = attention;
  endtask
endmodule

// *** aicsr_pkg.sv ***
/*
  Types of the analog input configuration and status register bank.
  Assumes the constants header supplies all numeric values.
*/
package aicsr_pkg;
  // one register word
  typedef logic [15:0] aicsr_word_t;
  // word address on the register port
  typedef logic [3:0] aicsr_addr_t;
  // operating mode, gray coded along warm -> run -> cal
  typedef enum logic [1:0] {
    AICSR_WARM = 2'b00,
    AICSR_RUN = 2'b01,
    AICSR_CAL = 2'b11
  } aicsr_mode_e;
endpackage

// *** aicsr_quality.sv ***
/*
  Per-channel point quality word for eight isolated channels.
  Assumes link fail flags are already synchronised and readings with
  their valid strobes come from converter logic on the same clock.
*/
`timescale 1ns/1ps
`include "aicsr_consts.svh"

module aicsr_quality (
  input wire logic mclk,
  input wire logic rst,
  input wire logic is_current,
  input wire logic [7:0] link_fail,
  input wire logic [7:0] ch_valid,
  input wire logic [127:0] ch_reading,
  output logic [15:0] quality
);
  import aicsr_pkg::*;

  logic [7:0] link_bad_ff; // link failure per channel
  logic [7:0] range_bad_ff; // overrange, blown fuse or open loop per channel

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : gen_ch
      aicsr_word_t rd; // this channel's latest reading
      logic out_of_range; // reading breaks the variant's limits
      assign rd = ch_reading[16*g +: 16];
      // current variant: unsigned microamps; voltage: signed hundredths of percent
      always_comb begin
        if (is_current) begin
          out_of_range = (rd < `AICSR_CUR_LOW_UA) || (rd > `AICSR_CUR_HIGH_UA);
        end else begin
          out_of_range = ($signed(rd) > $signed(`AICSR_VOLT_LIMIT)) ||
                         ($signed(rd) < -$signed(`AICSR_VOLT_LIMIT));
        end
      end
      // link bit follows the link state every cycle
      always_ff @(posedge mclk) begin
        if (rst) begin
          link_bad_ff[g] <= 1'b0;
        end else begin
          link_bad_ff[g] <= link_fail[g];
        end
      end
      // range bit only moves when a fresh conversion lands
      always_ff @(posedge mclk) begin
        if (rst) begin
          range_bad_ff[g] <= 1'b0;
        end else if (ch_valid[g]) begin
          range_bad_ff[g] <= out_of_range;
        end
      end
      // even bit link, odd bit range
      assign quality[2*g] = link_bad_ff[g];
      assign quality[2*g+1] = range_bad_ff[g];
    end
  endgenerate
endmodule

// *** aicsr_regs.sv ***
/*
  Configuration, status and point quality registers of an eight-channel
  isolated analog input module, with warm-up timing, conversion rate
  pacing and self-calibration sequencing.
  Assumes a register master on mclk that keeps strobes one cycle wide and
  never raises read and write together; link fail and variant pins are
  asynchronous, all other inputs come from logic on mclk.
*/
// Our own choice: the strobed register port.
// Summary of operation
// - write 13 loads config, read gives status
// - bit 0 configures; status bit 0 shows it
// - unconfigured reads of 0-11 give attention
// - bit 1 forces error; LED follows bit 1
// - error bit set: reads 0-11 give attention
// - warming for 8.16 s, error held meanwhile
// - bit 7 calibration checksum fail, LED, fault
// - bit 8 picks 20 or 25 conversions
// - bit 11 starts self-cal at two per second
// - bit 13 memory error, LED and fault
// - bit 15 ORs quality and bits 1,7,12,13
// - unused status bits read zero
// - address 14 reads zero
// - address 12 holds two quality bits per channel
// - link failure sets channel link bit
// - current outside 2.5-24.6 mA sets range bit
// - voltage beyond 121 percent sets range bit
// - quality word only shows pure channel faults
`timescale 1ns/1ps
`include "aicsr_consts.svh"

module aicsr_regs #(
  parameter int unsigned WARM_CYCLES = `AICSR_WARM_CYCLES,
  parameter int unsigned SAMPLE_60_CYCLES = `AICSR_SAMPLE_60_CYCLES,
  parameter int unsigned SAMPLE_50_CYCLES = `AICSR_SAMPLE_50_CYCLES,
  parameter int unsigned SAMPLE_CAL_CYCLES = `AICSR_SAMPLE_CAL_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire aicsr_pkg::aicsr_addr_t addr,
  input wire aicsr_pkg::aicsr_word_t wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output aicsr_pkg::aicsr_word_t rdata,
  output logic attention,
  output logic error_led,
  output logic rate_50hz,
  output logic self_cal_active,
  output logic sample_tick,
  input wire logic variant_current_pin,
  input wire logic [7:0] link_fail_pin,
  input wire logic [7:0] ch_valid,
  input wire logic [127:0] ch_reading,
  input wire logic cal_checksum_bad,
  input wire logic mem_error
);
  import aicsr_pkg::*;

  // register port state
  aicsr_word_t rdata_ff; // read data, valid the cycle after rd_stb
  logic attention_ff; // attention answer for a data word read
  // configuration fields
  logic configured_ff; // module configured by controller
  logic force_err_ff; // controller forced the error state
  logic rate_50hz_ff; // 1 selects 25 conversions per second
  // mode and timing
  aicsr_mode_e mode_ff; // warm, run or self-cal
  aicsr_mode_e nxt_mode;
  logic [29:0] warm_cnt_ff; // cycles spent warming
  logic [25:0] smp_cnt_ff; // cycles into the current sample period
  logic [25:0] smp_last; // last count of the current period
  logic smp_wrap; // end of sample period
  logic sample_tick_ff; // one cycle per sample
  logic [2:0] cal_cnt_ff; // samples taken in self-cal
  logic error_led_ff; // internal error indicator
  logic self_cal_ff; // self-cal indicator
  // three-stage synchronisers for pins
  logic [7:0] link_s1_ff;
  logic [7:0] link_s2_ff;
  logic [7:0] link_s3_ff;
  logic [7:0] link_ok_ff; // accepted link fail state
  logic var_s1_ff;
  logic var_s2_ff;
  logic var_s3_ff;
  logic variant_ff; // accepted current-variant strap
  // decoded status
  logic [15:0] quality; // per-channel quality bits
  logic warming;
  logic err_bit;
  logic point_fault;
  logic quality_visible;
  aicsr_word_t status_word;
  aicsr_word_t nxt_rdata;
  logic cfg_wr; // write to the configuration word
  logic data_rd; // read of a channel data word

  // strobe decode
  assign cfg_wr = wr_stb && (addr == `AICSR_ADDR_CFG_STAT);
  assign data_rd = rd_stb && (addr <= `AICSR_ADDR_LAST_DATA);

  // pins pass three flops; a change is taken once stages two and three agree
  always_ff @(posedge mclk) begin
    if (rst) begin
      link_s1_ff <= 8'h00;
      link_s2_ff <= 8'h00;
      link_s3_ff <= 8'h00;
      var_s1_ff <= 1'b0;
      var_s2_ff <= 1'b0;
      var_s3_ff <= 1'b0;
    end else begin
      link_s1_ff <= link_fail_pin;
      link_s2_ff <= link_s1_ff;
      link_s3_ff <= link_s2_ff;
      var_s1_ff <= variant_current_pin;
      var_s2_ff <= var_s1_ff;
      var_s3_ff <= var_s2_ff;
    end
  end

  // accepted values: per bit, only where the last two stages agree
  always_ff @(posedge mclk) begin
    if (rst) begin
      link_ok_ff <= 8'h00;
      variant_ff <= 1'b0;
    end else begin
      link_ok_ff <= (link_s2_ff & link_s3_ff) | (link_ok_ff & (link_s2_ff | link_s3_ff));
      if (var_s2_ff == var_s3_ff) begin
        variant_ff <= var_s3_ff;
      end
    end
  end

  // per-channel quality word
  aicsr_quality u_quality (
    .mclk(mclk),
    .rst(rst),
    .is_current(variant_ff),
    .link_fail(link_ok_ff),
    .ch_valid(ch_valid),
    .ch_reading(ch_reading),
    .quality(quality)
  );

  // configuration word; the diagnostic bits are not stored, a
  // controller is expected to write them as zero
  always_ff @(posedge mclk) begin
    if (rst) begin
      configured_ff <= `AICSR_CFG_RESET;
      force_err_ff <= `AICSR_CFG_RESET;
      rate_50hz_ff <= `AICSR_CFG_RESET;
    end else if (cfg_wr) begin
      configured_ff <= wdata[`AICSR_CFG_CONFIGURE];
      force_err_ff <= wdata[`AICSR_CFG_FORCE_ERR];
      rate_50hz_ff <= wdata[`AICSR_CFG_RATE_50HZ];
    end
  end

  // error and fault decode
  assign warming = (mode_ff == AICSR_WARM);
  // warm-up, checksum and memory faults all count as internal errors
  assign err_bit = force_err_ff | warming | cal_checksum_bad | mem_error;
  // status bit 12 (system cal failed) is always 0 outside factory test
  assign point_fault = (|quality) | err_bit | cal_checksum_bad | mem_error;
  // quality data is only shown when no module-level error explains the fault
  assign quality_visible = !err_bit && !cal_checksum_bad && !mem_error;

  // status word assembly; unused positions stay zero
  always_comb begin
    status_word = `AICSR_WORD_ZERO;
    status_word[`AICSR_ST_CONFIGURED] = configured_ff;
    status_word[`AICSR_ST_ERROR] = err_bit;
    status_word[`AICSR_ST_WARMING] = warming;
    status_word[`AICSR_ST_CAL_BAD] = cal_checksum_bad;
    status_word[`AICSR_ST_RATE_50HZ] = rate_50hz_ff;
    status_word[`AICSR_ST_MEM_ERR] = mem_error;
    status_word[`AICSR_ST_POINT_FAULT] = point_fault;
  end

  // read mux; data words 0-11 live in the converter path, here they read 0
  always_comb begin
    unique case (addr)
      `AICSR_ADDR_CFG_STAT: begin
        nxt_rdata = status_word;
      end
      `AICSR_ADDR_QUALITY: begin
        nxt_rdata = quality_visible ? quality : `AICSR_WORD_ZERO;
      end
      `AICSR_ADDR_SECONDARY: begin
        nxt_rdata = `AICSR_WORD_ZERO;
      end
      default: begin
        nxt_rdata = `AICSR_WORD_ZERO;
      end
    endcase
  end

  // read data register, valid only in the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_ff <= `AICSR_WORD_ZERO;
    end else if (rd_stb) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= `AICSR_WORD_ZERO;
    end
  end

  // attention answer for data reads while unconfigured or in error
  always_ff @(posedge mclk) begin
    if (rst) begin
      attention_ff <= 1'b0;
    end else begin
      attention_ff <= data_rd && (!configured_ff || err_bit);
    end
  end

  // mode sequencing: warm-up after reset, then run, self-cal on request
  always_comb begin
    nxt_mode = mode_ff;
    unique case (mode_ff)
      AICSR_WARM: begin
        if (warm_cnt_ff == 30'(WARM_CYCLES - 1)) begin
          nxt_mode = AICSR_RUN;
        end
      end
      AICSR_RUN: begin
        // a self-cal request during warm-up is dropped; sensors are not settled
        if (cfg_wr && wdata[`AICSR_CFG_SELF_CAL]) begin
          nxt_mode = AICSR_CAL;
        end
      end
      AICSR_CAL: begin
        if (smp_wrap && (cal_cnt_ff == `AICSR_CAL_SAMPLES - 3'h1)) begin
          nxt_mode = AICSR_RUN;
        end
      end
      default: begin
        nxt_mode = AICSR_WARM;
      end
    endcase
  end

  // mode register
  always_ff @(posedge mclk) begin
    if (rst) begin
      mode_ff <= AICSR_WARM;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // warm-up timer, restarted by every reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      warm_cnt_ff <= 30'h00000000;
    end else if (warming) begin
      warm_cnt_ff <= warm_cnt_ff + 30'h00000001;
    end
  end

  // sample period: self-cal overrides the line-frequency rate
  always_comb begin
    if (mode_ff == AICSR_CAL) begin
      smp_last = 26'(SAMPLE_CAL_CYCLES - 1);
    end else if (rate_50hz_ff) begin
      smp_last = 26'(SAMPLE_50_CYCLES - 1);
    end else begin
      smp_last = 26'(SAMPLE_60_CYCLES - 1);
    end
  end
  // >= so a shorter period chosen mid-count ends at once rather than wrapping
  assign smp_wrap = (smp_cnt_ff >= smp_last);

  // sample pacing counter; restarts on entry to self-cal
  always_ff @(posedge mclk) begin
    if (rst) begin
      smp_cnt_ff <= 26'h0000000;
      sample_tick_ff <= 1'b0;
    end else if (smp_wrap || (nxt_mode == AICSR_CAL && mode_ff != AICSR_CAL)) begin
      smp_cnt_ff <= 26'h0000000;
      sample_tick_ff <= smp_wrap;
    end else begin
      smp_cnt_ff <= smp_cnt_ff + 26'h0000001;
      sample_tick_ff <= 1'b0;
    end
  end

  // self-cal sample count
  always_ff @(posedge mclk) begin
    if (rst) begin
      cal_cnt_ff <= 3'h0;
    end else if (mode_ff != AICSR_CAL) begin
      cal_cnt_ff <= 3'h0;
    end else if (smp_wrap) begin
      cal_cnt_ff <= cal_cnt_ff + 3'h1;
    end
  end

  // indicators, registered so outputs leave from flops
  always_ff @(posedge mclk) begin
    if (rst) begin
      error_led_ff <= 1'b1;
      self_cal_ff <= 1'b0;
    end else begin
      error_led_ff <= err_bit;
      self_cal_ff <= (mode_ff == AICSR_CAL);
    end
  end

  // outputs
  assign rdata = rdata_ff;
  assign attention = attention_ff;
  assign error_led = error_led_ff;
  assign rate_50hz = rate_50hz_ff;
  assign self_cal_active = self_cal_ff;
  assign sample_tick = sample_tick_ff;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  logic rd_cfg;
  assign rd_cfg = rd_stb && (addr == `AICSR_ADDR_CFG_STAT);

  // the master leaves one idle cycle after a write, so the read lands two cycles later
  AST_CFG_READBACK: assert property (cfg_wr ##1 !cfg_wr ##1 rd_cfg |=>
      rdata[`AICSR_ST_CONFIGURED] == $past(wdata[`AICSR_CFG_CONFIGURE], 3))
    else $error("configured bit does not read back");
  AST_ATTN_UNCONF: assert property (data_rd && !configured_ff |=> attention)
    else $error("no attention on unconfigured data read");
  AST_ATTN_ERR: assert property (data_rd && err_bit |=> attention)
    else $error("no attention on data read in error");
  AST_FORCE_LED: assert property (cfg_wr && wdata[`AICSR_CFG_FORCE_ERR]
      |=> ##1 error_led)
    else $error("forced error did not light indicator");
  // the indicator trails the error bit by one flop, so check the very next cycle
  AST_WARM_ERR: assert property (warming |=> error_led)
    else $error("indicator dark during warm-up");
  AST_WARM_LEN: assert property (warming |-> warm_cnt_ff < 30'(WARM_CYCLES))
    else $error("warm-up overran its time");
  AST_CAL_FAULT: assert property (cal_checksum_bad && rd_cfg |=>
      rdata[`AICSR_ST_CAL_BAD] && rdata[`AICSR_ST_POINT_FAULT])
    else $error("calibration fault not reported");
  AST_MEM_FAULT: assert property (mem_error && rd_cfg |=>
      rdata[`AICSR_ST_MEM_ERR] && rdata[`AICSR_ST_POINT_FAULT] && error_led)
    else $error("memory fault not reported");
  AST_RATE: assert property (rd_cfg |=>
      rdata[`AICSR_ST_RATE_50HZ] == $past(rate_50hz_ff) && rate_50hz == $past(rate_50hz_ff))
    else $error("rate bit mismatch");
  AST_FAULT_OR: assert property (rd_cfg |=> rdata[`AICSR_ST_POINT_FAULT] ==
      ((|$past(quality)) | rdata[1] | rdata[7] | rdata[12] | rdata[13]))
    else $error("point fault is not the OR of its sources");
  AST_ZERO_BITS: assert property (rd_cfg |=> (rdata & 16'h5E6C) == 16'h0000)
    else $error("unused status bit set");
  AST_ADDR14: assert property (rd_stb && addr == `AICSR_ADDR_SECONDARY
      |=> rdata == 16'h0000)
    else $error("secondary word not zero");
  AST_QUAL_GATE: assert property (rd_stb && addr == `AICSR_ADDR_QUALITY
      && err_bit |=> rdata == 16'h0000)
    else $error("quality shown during module error");
  AST_CAL_START: assert property (mode_ff == AICSR_RUN && cfg_wr
      && wdata[`AICSR_CFG_SELF_CAL] |=> self_cal_active == 1'b0 ##1 self_cal_active)
    else $error("self-cal did not start");

  COV_CONFIG: cover property (cfg_wr && wdata[`AICSR_CFG_CONFIGURE] ##2 rd_cfg);
  COV_WARM_END: cover property (warming ##1 mode_ff == AICSR_RUN);
  COV_SELF_CAL: cover property (mode_ff == AICSR_CAL ##1 mode_ff == AICSR_RUN);
  COV_ATTN: cover property (data_rd ##1 attention);
endmodule

// *** aicsr_regs_bench.sv ***
/*
  Self-checking bench for the analog input register bank.
  Assumes the controller model drives the register port and that
  short timing parameters stand in for the real second-long counts.
*/
`timescale 1ns/1ps

module aicsr_regs_bench;
  import aicsr_pkg::*;
  // shortened counts; all expectations derive from these
  localparam int WARM = 50;
  localparam int S60 = 20;
  localparam int S50 = 16;
  localparam int SCAL = 40;
  logic mclk, rst, wr_stb, rd_stb, attention, error_led, rate_50hz;
  logic self_cal_active, sample_tick, variant_current_pin;
  logic cal_checksum_bad, mem_error, att;
  aicsr_addr_t addr;
  aicsr_word_t wdata, rdata, d;
  logic [7:0] link_fail_pin, ch_valid;
  logic [127:0] ch_reading;
  int n_errors, samples_checked, g, k;
  // range cases: {current variant, reading, expected quality}
  logic [32:0] tbl [8] = '{{1'b1, 16'h09C3, 16'h0002}, {1'b1, 16'h09C4, 16'h0000},
    {1'b1, 16'h6019, 16'h0002}, {1'b1, 16'h6018, 16'h0000},
    {1'b0, 16'h2F45, 16'h0002}, {1'b0, 16'h2F44, 16'h0000},
    {1'b0, 16'hD0BB, 16'h0002}, {1'b0, 16'hD0BC, 16'h0000}};

  aicsr_regs #(.WARM_CYCLES(WARM), .SAMPLE_60_CYCLES(S60), .SAMPLE_50_CYCLES(S50),
    .SAMPLE_CAL_CYCLES(SCAL)) u_aicsr_regs (.mclk(mclk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .attention(attention), .error_led(error_led), .rate_50hz(rate_50hz),
    .self_cal_active(self_cal_active), .sample_tick(sample_tick),
    .variant_current_pin(variant_current_pin), .link_fail_pin(link_fail_pin),
    .ch_valid(ch_valid), .ch_reading(ch_reading), .cal_checksum_bad(cal_checksum_bad),
    .mem_error(mem_error));

  aicsr_ctrl_model u_aicsr_ctrl_model (.mclk(mclk), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .attention(attention));

  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // single comparison point; four-state compare so x never matches
  task automatic chk(input string what, input aicsr_word_t seen, input aicsr_word_t exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // settled look at a one-bit output
  task automatic look(input string what, input logic seen, input logic exp);
    #1;
    chk(what, {15'h0000, seen}, {15'h0000, exp});
  endtask

  task automatic rd(input aicsr_addr_t a, input aicsr_word_t exp, input logic ea,
    input string what);
    u_aicsr_ctrl_model.read_word(a, d, att);
    chk(what, d, exp);
    chk({what, " attention"}, {15'h0000, att}, {15'h0000, ea});
  endtask

  task automatic wr(input aicsr_word_t v, input logic raw);
    u_aicsr_ctrl_model.write_word(4'hD, v, raw);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // cycles between two sample ticks, bounded so a dead tick cannot hang
  task automatic tick_gap(output int n);
    int i;
    i = 0;
    while (sample_tick !== 1'b1 && i < 300) begin
      @(posedge mclk);
      #1;
      i++;
    end
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (sample_tick !== 1'b1 && n < 300);
  endtask

  // one reading on channel 0 under a chosen variant strap
  task automatic rng(input logic cur, input logic [15:0] v, input aicsr_word_t exp);
    @(posedge mclk);
    variant_current_pin <= cur;
    ch_reading[15:0] <= v;
    cyc(5); // strap passes its synchroniser first
    ch_valid <= 8'h01;
    @(posedge mclk);
    ch_valid <= 8'h00;
    cyc(2);
    rd(4'hC, exp, 1'b0, "range quality");
  endtask

  task automatic conclude();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    cyc(5000);
    n_errors++;
    conclude();
  end

  // main sequence
  initial begin
    n_errors = 0;
    samples_checked = 0;
    rst = 1'b1;
    variant_current_pin = 1'b0;
    link_fail_pin = 8'h00;
    ch_valid = 8'h00;
    ch_reading = '0;
    cal_checksum_bad = 1'b0;
    mem_error = 1'b0;
    cyc(7);
    look("led in reset", error_led, 1'b1);
    @(posedge mclk);
    rst <= 1'b0;
    rd(4'hD, 16'h8012, 1'b0, "warm status");
    rd(4'h0, 16'h0000, 1'b1, "warm data");
    wr(16'h0800, 1'b0);
    cyc(2);
    look("cal in warmup", self_cal_active, 1'b0);
    cyc(WARM);
    rd(4'hD, 16'h0000, 1'b0, "warm done");
    rd(4'h3, 16'h0000, 1'b1, "unconfigured data");
    rd(4'hE, 16'h0000, 1'b0, "secondary");
    rd(4'hF, 16'h0000, 1'b0, "unmapped");
    u_aicsr_ctrl_model.write_word(4'hC, 16'hFFFF, 1'b1);
    wr(16'h0001, 1'b0);
    rd(4'hD, 16'h0001, 1'b0, "configured");
    rd(4'hB, 16'h0000, 1'b0, "configured data");
    wr(16'h04FD, 1'b1);
    rd(4'hD, 16'h0001, 1'b0, "unused bits");
    // forced error, with a link fault hidden behind it
    wr(16'h0003, 1'b0);
    link_fail_pin <= 8'h04;
    rd(4'hD, 16'h8003, 1'b0, "forced error");
    look("forced led", error_led, 1'b1);
    rd(4'hB, 16'h0000, 1'b1, "error data");
    cyc(6);
    rd(4'hC, 16'h0000, 1'b0, "gated quality");
    wr(16'h0001, 1'b0);
    cyc(2);
    look("led off", error_led, 1'b0);
    rd(4'hC, 16'h0010, 1'b0, "link quality");
    rd(4'hD, 16'h8001, 1'b0, "point fault");
    link_fail_pin <= 8'h00;
    cyc(8);
    rd(4'hC, 16'h0000, 1'b0, "link cleared");
    cal_checksum_bad <= 1'b1;
    cyc(2);
    rd(4'hD, 16'h8083, 1'b0, "cal bad");
    look("cal led", error_led, 1'b1);
    cal_checksum_bad <= 1'b0;
    mem_error <= 1'b1;
    cyc(2);
    rd(4'hD, 16'hA003, 1'b0, "memory error");
    look("memory led", error_led, 1'b1);
    mem_error <= 1'b0;
    cyc(2);
    for (k = 0; k < 8; k++)
      rng(tbl[k][32], tbl[k][31:16], tbl[k][15:0]);
    // conversion rate selection
    wr(16'h0101, 1'b0);
    rd(4'hD, 16'h0101, 1'b0, "50 Hz status");
    look("rate pin", rate_50hz, 1'b1);
    tick_gap(g);
    tick_gap(g);
    chk("50 Hz period", 16'(g), 16'(S50));
    wr(16'h0001, 1'b0);
    tick_gap(g);
    tick_gap(g);
    chk("60 Hz period", 16'(g), 16'(S60));
    // self-calibration paces at its own slow rate, then returns
    wr(16'h0801, 1'b0);
    rd(4'hD, 16'h0001, 1'b0, "cal status");
    look("cal active", self_cal_active, 1'b1);
    tick_gap(g);
    tick_gap(g);
    chk("cal period", 16'(g), 16'(SCAL));
    k = 0;
    while (self_cal_active === 1'b1 && k < 4 * SCAL) begin
      @(posedge mclk);
      #1;
      k++;
    end
    look("cal ended", self_cal_active, 1'b0);
    // reset in mid-run clears the configuration again
    wr(16'h0103, 1'b0);
    @(posedge mclk);
    rst <= 1'b1;
    cyc(2);
    look("rate after reset", rate_50hz, 1'b0);
    @(posedge mclk);
    rst <= 1'b0;
    rd(4'hD, 16'h8012, 1'b0, "status after reset");
    conclude();
  end
endmodule
